// ==== hdl/cgmc_top.sv ====
// Purpose: Clock generator and master clock control with AHB-Lite registers.
// Assumes: hclk 20 MHz; slow and main clocks arrive as pins and are sampled.
// Notes:   Main clock measurement is only exact below a quarter of the bus clock.
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
module cgmc_top
  import cgmc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        slow_clock_in,
  input  wire logic        main_clock_in,
  input  wire logic        cpu_instr_done,
  input  wire logic        cpu_fiq_req,
  input  wire logic        cpu_irq_req,
  output logic             osc_enable_o,
  output logic             osc_bypass_o,
  output logic [7:0]       pll_div_o,
  output logic [10:0]      pll_mul_o,
  output logic             pll_gate_o,
  output logic [1:0]       usb_divider_o,
  output logic [1:0]       master_source_o,
  output logic [2:0]       master_prescaler_o,
  output logic             processor_clock_en_o,
  output logic             usb_clock_en_o,
  output logic             irq_o
);

  logic                 slow_lvl;
  logic                 slow_rise;
  logic                 slow_fall;
  logic                 main_rise;
  logic                 wr_pend_r;
  logic                 rd_pend_r;
  logic [7:0]           wr_addr_r;
  logic [7:0]           rd_addr_r;
  logic                 osc_run_r;
  logic [OSC_CNT_W-1:0] osc_cnt_r;
  logic [2:0]           osc_div_r;
  logic                 osc_stable_r;
  cgmc_fc_state_t       fc_state_r;
  logic [3:0]           fc_edges_r;
  logic [FREQ_W-1:0]    freq_cnt_r;
  logic                 freq_ready_r;
  logic [PLL_CNT_W-1:0] pll_lock_cnt_r;
  logic [PLL_CNT_W-1:0] pll_cnt_r;
  logic                 pll_run_r;
  logic                 pll_lock_r;
  logic [1:0]           src_sel_r;
  logic [1:0]           settle_r;
  logic                 master_rdy_r;
  logic                 stop_pend_r;
  logic [SR_W-1:0]      imr_r;

  // Pin samplers for the two incoming clocks
  cgmc_sync u_slow (
    .clk      (hclk),
    .rst_n    (hresetn),
    .async_in (slow_clock_in),
    .level    (slow_lvl),
    .rise     (slow_rise),
    .fall     (slow_fall)
  );

  cgmc_sync u_main (
    .clk      (hclk),
    .rst_n    (hresetn),
    .async_in (main_clock_in),
    .level    (),
    .rise     (main_rise),
    .fall     ()
  );

  // Bus decode
  wire        bus_acc  = hsel & hready & htrans[1];
  wire        wr_scer  = wr_pend_r && (wr_addr_r == A_SCER);
  wire        wr_scdr  = wr_pend_r && (wr_addr_r == A_SCDR);
  wire        wr_mor   = wr_pend_r && (wr_addr_r == A_MOR);
  wire        wr_pll   = wr_pend_r && (wr_addr_r == A_PLLR);
  wire        wr_master = wr_pend_r && (wr_addr_r == A_MCKR);
  wire        wr_imr   = wr_pend_r && (wr_addr_r == A_IMR);

  // Write fields
  wire        w_osc_en = hwdata[MOR_EN_BIT];
  wire [OSC_CNT_W-1:0] w_osc_cnt = hwdata[MOR_CNT_LSB +: OSC_CNT_W];
  wire [PLL_DIV_W-1:0] w_div     = hwdata[PLL_DIV_LSB +: PLL_DIV_W];
  wire [PLL_MUL_W-1:0] w_mul     = hwdata[PLL_MUL_LSB +: PLL_MUL_W];
  wire [PLL_CNT_W-1:0] w_pcnt    = hwdata[PLL_CNT_LSB +: PLL_CNT_W];
  wire [MPRE_W-1:0] w_scale_raw = hwdata[MPRE_LSB +: MPRE_W];
  wire [MPRE_W-1:0] w_scale     =
    (w_scale_raw > PRESCALE_MAX) ? PRESCALE_MAX : w_scale_raw; // RULE16

  // Parameter change or re-enable restarts the lock count
  wire pll_change = wr_pll &&
                    ((w_mul != pll_mul_o) || (w_div != pll_div_o));
  wire pll_bump   = pll_change && (src_sel_r == SRC_PLL);
  wire pll_unlock = (src_sel_r == SRC_PLL) && !pll_lock_r;
  wire cpu_wake   = cpu_fiq_req | cpu_irq_req;

  // Readable state
  wire [SR_W-1:0] sr_bits = {master_rdy_r, pll_lock_r, 1'b0, osc_stable_r};
  wire [31:0] rd_sc   = {24'h0, usb_clock_en_o, 6'h0, processor_clock_en_o};
  wire [31:0] rd_mor  = {16'h0, osc_cnt_r, 6'h0, osc_bypass_o, osc_enable_o};
  wire [31:0] rd_mcfr = {15'h0, freq_ready_r, freq_cnt_r};
  wire [31:0] rd_pll  = {2'h0, usb_divider_o, 1'b0, pll_mul_o,
                         2'h0, pll_lock_cnt_r, pll_div_o};
  wire [31:0] rd_master = {27'h0, master_prescaler_o, src_sel_r};
  wire [31:0] rd_mux  =
    (rd_addr_r == A_SCSR) ? rd_sc :                         // RULE18
    (rd_addr_r == A_MOR)  ? rd_mor :
    (rd_addr_r == A_MCFR) ? rd_mcfr :                       // RULE26
    (rd_addr_r == A_PLLR) ? rd_pll :
    (rd_addr_r == A_MCKR) ? rd_master :
    (rd_addr_r == A_SR)   ? {28'h0, sr_bits} :
    (rd_addr_r == A_IMR)  ? {28'h0, imr_r} : 32'h0;

  // Bus slave: writes no wait, reads one wait so a write ahead lands first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rd_addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
    end else begin
      wr_pend_r <= bus_acc & hwrite;
      rd_pend_r <= bus_acc & ~hwrite;
      wr_addr_r <= haddr[7:0];
      rd_addr_r <= haddr[7:0];
      hreadyout <= ~(bus_acc & ~hwrite);
      hresp     <= 1'b0;
      if (rd_pend_r) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Main oscillator enable and start-up count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_enable_o <= 1'b0;                                 // RULE1
      osc_bypass_o <= 1'b0;
      osc_run_r    <= 1'b0;
      osc_cnt_r    <= 8'h00;
      osc_div_r    <= 3'h0;
      osc_stable_r <= 1'b0;
    end else if (wr_mor) begin
      osc_enable_o <= w_osc_en;
      osc_bypass_o <= hwdata[MOR_BYP_BIT];                  // RULE7
      osc_run_r    <= w_osc_en;                             // RULE3
      osc_cnt_r    <= w_osc_cnt;                            // RULE3
      osc_div_r    <= 3'h0;
      osc_stable_r <= 1'b0;                                 // RULE2
    end else if (osc_run_r && (osc_cnt_r == 8'h00)) begin
      osc_run_r    <= 1'b0;
      osc_stable_r <= 1'b1;                                 // RULE4
    end else if (osc_run_r && slow_rise) begin
      osc_div_r    <= osc_div_r + 3'h1;
      if (osc_div_r == OSC_DIV_LAST) begin
        osc_cnt_r  <= osc_cnt_r - 8'h01;                    // RULE3
      end
    end
  end

  // Frequency measurement from a slow rise to the sixteenth slow fall
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fc_state_r   <= FC_IDLE;
      fc_edges_r   <= 4'h0;
      freq_cnt_r   <= 16'h0;
      freq_ready_r <= 1'b0;
    end else if (!osc_stable_r) begin
      fc_state_r   <= FC_IDLE;
      freq_ready_r <= 1'b0;
    end else begin
      unique case (fc_state_r)
        FC_IDLE: begin
          fc_state_r <= FC_WAIT_RISE;                       // RULE5
          freq_cnt_r <= 16'h0;
          fc_edges_r <= 4'h0;
        end
        FC_WAIT_RISE: begin
          if (slow_rise) begin
            fc_state_r <= FC_COUNT;                         // RULE5
          end
        end
        FC_COUNT: begin
          if (main_rise) begin
            freq_cnt_r <= freq_cnt_r + 16'h1;
          end
          if (slow_fall) begin
            fc_edges_r <= fc_edges_r + 4'h1;
            if (fc_edges_r == FREQ_LAST) begin
              fc_state_r   <= FC_DONE;                      // RULE6
              freq_ready_r <= 1'b1;                         // RULE6
            end
          end
        end
        FC_DONE: begin
          fc_state_r <= FC_DONE;
        end
      endcase
    end
  end

  // PLL parameters and lock counter, stepping on slow ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_div_o      <= 8'h00;                              // RULE9
      pll_mul_o      <= 11'h000;
      usb_divider_o  <= 2'h0;
      pll_lock_cnt_r <= 6'h00;
      pll_cnt_r      <= 6'h00;
      pll_run_r      <= 1'b0;
      pll_lock_r     <= 1'b0;
      pll_gate_o     <= 1'b0;
    end else begin
      if (wr_pll) begin
        pll_div_o      <= w_div;                            // RULE10
        pll_mul_o      <= w_mul;                            // RULE10
        usb_divider_o  <= hwdata[PLL_USB_LSB +: PLL_USB_W]; // RULE23
        pll_lock_cnt_r <= w_pcnt;
        pll_gate_o     <= (w_mul != 11'h000) &&
                          (w_div != 8'h00);                 // RULE8 RULE11
      end
      if (pll_change) begin
        pll_lock_r <= 1'b0;                                 // RULE12
        pll_cnt_r  <= w_pcnt;                               // RULE12
        pll_run_r  <= (w_mul != 11'h000) && (w_div != 8'h00);
      end else if (pll_run_r && (pll_cnt_r == 6'h00)) begin
        pll_run_r  <= 1'b0;
        pll_lock_r <= 1'b1;                                 // RULE13
      end else if (pll_run_r && slow_rise) begin
        pll_cnt_r  <= pll_cnt_r - 6'h01;                    // RULE13 RULE26
      end
    end
  end

  // Master clock source, prescaler and ready flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_sel_r          <= SRC_SLOW;                       // RULE1
      master_prescaler_o <= 3'h0;
      master_source_o    <= SRC_SLOW;
      settle_r           <= 2'h0;
      master_rdy_r       <= 1'b1;
    end else begin
      master_source_o <= pll_unlock ? SRC_MAIN : src_sel_r; // RULE15 RULE24
      if (wr_master) begin
        src_sel_r          <= hwdata[MSRC_SEL_LSB +: MSRC_SEL_W];
        master_prescaler_o <= w_scale;                      // RULE16
      end
      if (wr_master || pll_bump) begin
        master_rdy_r <= 1'b0;                               // RULE17 RULE24
        settle_r     <= MASTER_SETTLE;
      end else if (settle_r != 2'h0) begin
        if (slow_rise) begin
          settle_r <= settle_r - 2'h1;
        end
      end else if (!pll_unlock) begin
        master_rdy_r <= 1'b1;                               // RULE17 RULE24
      end
    end
  end

  // Processor idle gating and USB clock gate; wake beats a stop request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      processor_clock_en_o <= 1'b1;                         // RULE19
      stop_pend_r          <= 1'b0;
      usb_clock_en_o       <= 1'b0;
    end else begin
      if ((wr_scer && hwdata[SC_PROC_BIT]) || cpu_wake) begin
        processor_clock_en_o <= 1'b1;                       // RULE19
        stop_pend_r          <= 1'b0;
      end else if (wr_scdr && hwdata[SC_PROC_BIT]) begin
        stop_pend_r          <= 1'b1;                       // RULE18
      end else if (stop_pend_r && cpu_instr_done) begin
        processor_clock_en_o <= 1'b0;                       // RULE20
        stop_pend_r          <= 1'b0;
      end
      if (wr_scdr && hwdata[SC_USB_BIT]) begin
        usb_clock_en_o <= 1'b0;                             // RULE21
      end else if (wr_scer && hwdata[SC_USB_BIT] && pll_lock_r) begin
        usb_clock_en_o <= 1'b1;                             // RULE21
      end
    end
  end

  // Interrupt mask and request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      imr_r <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      if (wr_imr) begin
        imr_r <= hwdata[SR_W-1:0];
      end
      irq_o <= |(sr_bits & imr_r);                          // RULE4 RULE25
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_OSC_OFF: assert property ( // RULE2
    wr_mor && !w_osc_en |=> !osc_stable_r && !osc_enable_o)
    else $error("stable flag survived oscillator disable");
  AST_OSC_LOAD: assert property ( // RULE3
    wr_mor && w_osc_en |=> !osc_stable_r && osc_cnt_r == $past(w_osc_cnt))
    else $error("start-up count not loaded");
  AST_OSC_DONE: assert property ( // RULE4
    osc_run_r && osc_cnt_r == 8'h00 && !wr_mor |=> osc_stable_r)
    else $error("stable flag not set at zero count");
  AST_FREQ_WAIT: assert property ( // RULE5
    $rose(osc_stable_r) |=> fc_state_r == FC_WAIT_RISE ##1 !freq_ready_r)
    else $error("frequency counter did not wait for slow rise");
  AST_FREQ_END: assert property ( // RULE6
    fc_state_r == FC_COUNT && slow_fall && fc_edges_r == FREQ_LAST &&
    osc_stable_r && !wr_mor |=> freq_ready_r && fc_state_r == FC_DONE)
    else $error("frequency counter did not stop");
  AST_PLL_GATE: assert property ( // RULE8
    wr_pll && (w_div == 8'h00 || w_mul == 11'h000) |=> !pll_gate_o)
    else $error("PLL not held off");
  AST_PLL_RELOAD: assert property ( // RULE12
    pll_change |=> !pll_lock_r && pll_cnt_r == $past(w_pcnt))
    else $error("lock not cleared on PLL change");
  AST_PLL_LOCK: assert property ( // RULE13
    pll_run_r && pll_cnt_r == 6'h00 && !pll_change |=> pll_lock_r)
    else $error("lock not set at zero count");
  AST_MASTER_CLR: assert property ( // RULE17
    wr_master |=> !master_rdy_r ##1 !master_rdy_r)
    else $error("ready not cleared by master clock write");
  AST_FALLBACK: assert property ( // RULE24
    pll_unlock |=> master_source_o == SRC_MAIN && !master_rdy_r)
    else $error("no fallback to main clock while unlocked");
  AST_WAKE: assert property ( // RULE19
    cpu_wake |=> processor_clock_en_o && !stop_pend_r)
    else $error("processor clock not woken");
  AST_USB_LOCK: assert property ( // RULE21
    $rose(usb_clock_en_o) |-> $past(pll_lock_r))
    else $error("USB clock enabled without lock");
  AST_IRQ: assert property ( // RULE25
    |(sr_bits & imr_r) |=> irq_o)
    else $error("interrupt request missing");

endmodule : cgmc_top

// ==== hdl/cgmc_pkg.sv ====
// Purpose: Constants and types for the clock generator and master clock
//          control block.
// Assumes: AHB-Lite register access, 32-bit data, word-aligned registers.
// Notes:   Notes on the behaviour of the block follow.
// Notes on behaviour
// RULE1 - After reset main oscillator off and master clock from slow clock.
// RULE2 - Clearing oscillator enable clears the stable flag at once.
// RULE3 - Enable write clears stable, loads count, counts down on slow/8.
// RULE4 - Count at zero sets stable flag; mask bit lets it request an irq.
// RULE5 - Frequency counting starts after next slow rise once stable is set.
// RULE6 - Sixteenth slow falling edge stops frequency counter, sets ready.
// RULE7 - For an external clock software sets bypass to 1, enable to 0.
// RULE8 - Divider takes 1 to 255; zero holds divider and PLL output low.
// RULE9 - Reset clears divider, so PLL input stays low until programmed.
// RULE10 - PLL output is source times multiplier plus one over divider.
// RULE11 - Multiplier zero powers the PLL down; non-zero enables it again.
// RULE12 - PLL re-enable or parameter change clears lock, reloads counter.
// RULE13 - PLL counter steps per slow cycle; zero sets lock flag.
// RULE14 - Software loads a lock count that covers the filter transient.
// RULE15 - Master clock comes from the selected source, slow clock included.
// RULE16 - Master prescaler divides by a power of two from 1 to 64.
// RULE17 - Every master clock write clears ready until clock established.
// RULE18 - Disable write stops processor clock; status register shows it.
// RULE19 - Processor clock on after reset, woken by fast or normal irq.
// RULE20 - Processor stops after current instruction; bus keeps running.
// RULE21 - With PLL locked software gates USB clock; status shows it.
// RULE22 - Software programs PLL to 48, 96 or 192 MHz for USB.
// RULE23 - USB divider divides PLL output by 1, 2 or 4.
// RULE24 - PLL rewrite while selected falls back to main, ready held low.
// RULE25 - Interrupt request while any masked-in status flag is set.
// RULE26 - Counters run on slow clock ticks, results read on bus clock.
package cgmc_pkg;

  // Register byte offsets
  localparam logic [7:0] A_SCER = 8'h00;
  localparam logic [7:0] A_SCDR = 8'h04;
  localparam logic [7:0] A_SCSR = 8'h08;
  localparam logic [7:0] A_MOR  = 8'h0c;
  localparam logic [7:0] A_MCFR = 8'h10;
  localparam logic [7:0] A_PLLR = 8'h14;
  localparam logic [7:0] A_MCKR = 8'h18;
  localparam logic [7:0] A_SR   = 8'h1c;
  localparam logic [7:0] A_IMR  = 8'h20;

  // System clock bits
  localparam int SC_PROC_BIT = 0;
  localparam int SC_USB_BIT  = 7;

  // Oscillator control fields
  localparam int MOR_EN_BIT  = 0;
  localparam int MOR_BYP_BIT = 1;
  localparam int MOR_CNT_LSB = 8;
  localparam int OSC_CNT_W   = 8;

  // PLL control fields
  localparam int PLL_DIV_LSB = 0;
  localparam int PLL_DIV_W   = 8;
  localparam int PLL_CNT_LSB = 8;
  localparam int PLL_CNT_W   = 6;
  localparam int PLL_MUL_LSB = 16;
  localparam int PLL_MUL_W   = 11;
  localparam int PLL_USB_LSB = 28;
  localparam int PLL_USB_W   = 2;

  // Master clock fields and encodings
  localparam int MSRC_SEL_LSB = 0;
  localparam int MSRC_SEL_W   = 2;
  localparam int MPRE_LSB     = 2;
  localparam int MPRE_W       = 3;
  localparam logic [1:0] SRC_SLOW     = 2'h0;
  localparam logic [1:0] SRC_MAIN     = 2'h1;
  localparam logic [1:0] SRC_PLL      = 2'h3;
  localparam logic [2:0] PRESCALE_MAX = 3'h6;

  // Status bits, frequency register layout
  localparam int SR_OSC_BIT   = 0;
  localparam int SR_LOCK_BIT  = 2;
  localparam int SR_MCK_BIT   = 3;
  localparam int SR_W         = 4;
  localparam int FREQ_W       = 16;
  localparam int MCFR_RDY_BIT = 16;

  // Timing counts in slow clock ticks
  localparam logic [2:0] OSC_DIV_LAST  = 3'h7;
  localparam logic [3:0] FREQ_LAST     = 4'hf;
  localparam logic [1:0] MASTER_SETTLE = 2'h2;

  typedef enum logic [1:0] {
    FC_IDLE,
    FC_WAIT_RISE,
    FC_COUNT,
    FC_DONE
  } cgmc_fc_state_t;

endpackage : cgmc_pkg

// ==== hdl/cgmc_sync.sv ====
// Purpose: Three-stage sampler for a clock pin seen on the bus clock.
// Assumes: Input is asynchronous to clk and much slower than clk.
// Notes:   Level changes only when stages two and three agree.
`timescale 1ns/1ns
module cgmc_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // First stage feeds only the second, against metastability
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      level <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      s1_r  <= async_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      rise  <= (s2_r == s3_r) && s3_r && !level;
      fall  <= (s2_r == s3_r) && !s3_r && level;
      if (s2_r == s3_r) begin
        level <= s3_r;
      end
    end
  end

endmodule : cgmc_sync

// ==== tb/cgmc_clk_model.sv ====
// Purpose: Stand-in for the slow RC clock and the main oscillator pin.
// Assumes: Slow clock always runs; main clock only when enabled or bypassed.
// Notes:   Main pin sits low while enable and bypass are both off.
`timescale 1ns/1ns
module cgmc_clk_model #(
  parameter int SLOW_HALF = 1000,
  parameter int MAIN_HALF = 200
) (
  output logic     slow_clock,
  output logic     main_clock,
  input wire logic osc_enable,
  input wire logic osc_bypass
);
  // Slow clock is permanent, never stops
  initial slow_clock = 1'b0;
  always #SLOW_HALF slow_clock = ~slow_clock;

  // Dead crystal gives a flat pin, external clock runs on bypass
  initial main_clock = 1'b0;
  always begin
    #MAIN_HALF;
    if (osc_enable || osc_bypass) main_clock = ~main_clock;
    else main_clock = 1'b0;
  end
endmodule : cgmc_clk_model

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the clock control block.
// Assumes: Slow period 2000 ns, main period 400 ns, so about 77 counted
//          from a slow rise to the sixteenth slow fall.
// Notes:   Status is polled over the bus with bounded loops.
`timescale 1ns/1ns
module tb_top;
  import cgmc_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        cpu_done, cpu_fiq, cpu_irq, slow_ck, main_ck;
  logic        osc_en, osc_byp, pll_gate, proc_en, usb_en, irq;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans, usb_div, msrc;
  logic [2:0]  mpres;
  logic [7:0]  pdiv;
  logic [10:0] pmul;
  int          error_cnt, checks;

  // Bus clock 20 MHz
  initial hclk = 1'b0;
  always #25 hclk = ~hclk;

  cgmc_clk_model u_clk (.slow_clock(slow_ck), .main_clock(main_ck),
    .osc_enable(osc_en), .osc_bypass(osc_byp));

  cgmc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .slow_clock_in(slow_ck),
    .main_clock_in(main_ck), .cpu_instr_done(cpu_done),
    .cpu_fiq_req(cpu_fiq), .cpu_irq_req(cpu_irq), .osc_enable_o(osc_en),
    .osc_bypass_o(osc_byp), .pll_div_o(pdiv), .pll_mul_o(pmul),
    .pll_gate_o(pll_gate), .usb_divider_o(usb_div),
    .master_source_o(msrc), .master_prescaler_o(mpres),
    .processor_clock_en_o(proc_en), .usb_clock_en_o(usb_en),
    .irq_o(irq));

  task automatic end_sim();
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp

  // Ready is looked at mid-cycle, so the edge that follows ends the phase
  task automatic rdy_wait();
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: bus hang", $time);
      end_sim();
    end
    @(posedge hclk);
  endtask : rdy_wait

  // One single word transfer, address phase then data phase
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy_wait();
    rd = hrdata;
    cmp({31'h0, hresp}, 32'h0);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    xfer(1'b1, {24'h0, a}, v, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    xfer(1'b0, {24'h0, a}, 32'h0, v);
  endtask : rd

  // Read until a status bit comes up
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      rd(a, d);
      n++;
    end while ((d & m) !== m && n < 600);
    cmp(d & m, m);
    if ((d & m) !== m) end_sim();
  endtask : poll

  task automatic t_reset();
    cmp({27'h0, osc_en, msrc, proc_en, pll_gate}, 32'h2);
    rd(A_SR, d); cmp(d, 32'h8);
    rd(A_PLLR, d); cmp(d, 32'h0);
    rd(A_SCSR, d); cmp(d, 32'h1);
    rd(8'h24, d); cmp(d, 32'h0);
    rd(A_SCER, d); cmp(d, 32'h0);
  endtask : t_reset

  task automatic t_osc();
    wr(A_IMR, 32'h1);
    wr(A_MOR, 32'h201);
    rd(A_SR, d); cmp(d & 32'h1, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    poll(A_SR, 32'h1);
    repeat (2) @(posedge hclk);
    cmp({31'h0, irq}, 32'h1);
    poll(A_MCFR, 32'h10000);
    checks++;
    if (d[15:0] < 16'h4c || d[15:0] > 16'h4e) begin
      error_cnt++;
      $display("unexpected at %0t: count %h", $time, d[15:0]);
    end
    wr(A_IMR, 32'h0);
  endtask : t_osc

  task automatic t_pll();
    wr(A_PLLR, 32'h10030401);
    rd(A_SR, d); cmp(d & 32'h4, 32'h0);
    poll(A_SR, 32'h4);
    cmp({10'h0, pll_gate, pmul, pdiv, usb_div}, 32'h200c05);
    wr(A_SCER, 32'h80);
    rd(A_SCSR, d); cmp(d, 32'h81);
    cmp({31'h0, usb_en}, 32'h1);
  endtask : t_pll

  task automatic t_master();
    wr(A_MCKR, 32'h13);
    rd(A_SR, d); cmp(d & 32'h8, 32'h0);
    poll(A_SR, 32'h8);
    cmp({27'h0, msrc, mpres}, 32'h1c);
    wr(A_PLLR, 32'h10050401);
    rd(A_SR, d); cmp(d & 32'hc, 32'h0);
    cmp({30'h0, msrc}, 32'h1);
    poll(A_SR, 32'hc);
    cmp({30'h0, msrc}, 32'h3);
    wr(A_MCKR, 32'h1d);
    rd(A_MCKR, d); cmp(d, 32'h19);
    poll(A_SR, 32'h8);
    cmp({27'h0, msrc, mpres}, 32'he);
  endtask : t_master

  task automatic t_gate();
    wr(A_PLLR, 32'h10030400);
    @(posedge hclk);
    cmp({31'h0, pll_gate}, 32'h0);
    wr(A_PLLR, 32'h10000401);
    @(posedge hclk);
    cmp({31'h0, pll_gate}, 32'h0);
    wr(A_PLLR, 32'h10030401);
    poll(A_SR, 32'h4);
    cmp({31'h0, pll_gate}, 32'h1);
  endtask : t_gate

  // Idle entry waits for the instruction, wake-up by interrupt
  task automatic t_cpu();
    wr(A_SCDR, 32'h81);
    repeat (4) @(posedge hclk);
    cmp({30'h0, usb_en, proc_en}, 32'h1);
    cpu_done <= 1'b1;
    repeat (4) @(posedge hclk);
    rd(A_SCSR, d); cmp(d, 32'h0);
    cpu_irq <= 1'b1;
    repeat (4) @(posedge hclk);
    cmp({31'h0, proc_en}, 32'h1);
    cpu_irq <= 1'b0;
    wr(A_SCDR, 32'h1);
    repeat (4) @(posedge hclk);
    cmp({31'h0, proc_en}, 32'h0);
    cpu_fiq <= 1'b1;
    repeat (4) @(posedge hclk);
    cmp({31'h0, proc_en}, 32'h1);
  endtask : t_cpu

  task automatic t_osc_off();
    wr(A_MOR, 32'h0);
    rd(A_SR, d); cmp(d & 32'h1, 32'h0);
    cmp({31'h0, osc_en}, 32'h0);
    wr(A_MOR, 32'h2);
    rd(A_MOR, d); cmp(d, 32'h2);
    cmp({31'h0, osc_byp}, 32'h1);
  endtask : t_osc_off

  // Main sequence
  initial begin
    error_cnt = 0;
    checks = 0;
    hresetn <= 1'b0;
    {hsel, hwrite, cpu_done, cpu_fiq, cpu_irq} <= 5'h0;
    haddr <= 32'h0;
    hwdata <= 32'h0;
    htrans <= 2'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    t_reset();
    t_osc();
    t_pll();
    t_master();
    t_gate();
    t_cpu();
    t_osc_off();
    end_sim();
  end
endmodule : tb_top
